// [verilog/position_capture_ring.sv]
// How it works
// - Each entry holds axis, rise bits, fall bits, home bits and encoder position.
// - Home and each input trigger on rising, falling or any edge.
// - Axes without incremental encoder never produce entries.
// - Events seen at a motor update tick are copied into the ring.
// - Data waiting shows as bit 8 of status word two at 0xFC8.
// - Same flag reads as bit 0 of byte 0xFCA.
// - Entry goes to the insert slot, then insert index advances one slot.
// - If advanced insert meets removal, removal also advances, dropping oldest.
// - Capture area spans offsets 0xD94 through 0xFBB.
// - Insert index byte at 0xD94, removal index byte at 0xD95.
// - Table starts at 0xD96, 55 entries of 10 bytes.
// - Bytes 0-3 position MSB first, byte 4 axis number.
// - Byte 5: 0x01 home rise, 0x02 encoder home, 0x04 home fall.
// - Bytes 6-7 rise mask, 8-9 fall mask, MSB first.
// - A trigger bit is set only when that input caused capture.
// - Back to back events on one axis give several pending entries.
`timescale 1ns/1ns
`include "capture_defines.svh"
module position_capture_ring
  import capture_pkg::*;
(
  input  wire logic                       clock,
  input  wire logic                       rst,
  input  wire logic                       update_tick,
  input  wire logic [`NUM_AXES-1:0]       home_pin,
  input  wire logic [`NUM_AXES-1:0]       index_pin,
  input  wire logic [`NUM_GPIO-1:0]       gpio_pin,
  input  wire logic [`NUM_AXES*32-1:0]    enc_pos,
  input  wire logic [`NUM_AXES-1:0]       has_encoder,
  input  wire logic [`NUM_AXES*2-1:0]     home_sel,
  input  wire logic [`NUM_GPIO*2-1:0]     gpio_sel,
  input  wire logic [1:0]                 gpio_axis,
  input  wire logic [11:0]                host_addr,
  input  wire logic                       host_rd,
  input  wire logic                       host_wr,
  input  wire logic [7:0]                 host_wdata,
  output logic      [7:0]                 host_rdata,
  output logic                            data_waiting
);
  localparam int NP = `NUM_AXES + `NUM_AXES + `NUM_GPIO;

  // ==========================================================
  // Registered control state of the block
  typedef struct packed {
    logic [NP-1:0]            s1;
    logic [NP-1:0]            s2;
    logic [NP-1:0]            s3;
    logic [NP-1:0]            lvl;
    logic [`NUM_AXES*3-1:0]   home_pend;
    logic [`NUM_GPIO-1:0]     rise_pend;
    logic [`NUM_GPIO-1:0]     fall_pend;
    logic [`NUM_AXES*3-1:0]   home_snap;
    logic [`NUM_GPIO-1:0]     rise_snap;
    logic [`NUM_GPIO-1:0]     fall_snap;
    logic [1:0]               snap_gaxis;
    logic                     scanning;
    logic [1:0]               scan_axis;
    wr_state_e                wst;
    record_s                  rec;
    logic [3:0]               byte_k;
    logic [7:0]               ins;
    logic [7:0]               rem;
    logic [7:0]               rdata;
  } state_s;

  state_s    q;
  state_s    d;
  logic [7:0] ring_q [`TABLE_BYTES];
  logic       mem_we;
  logic [9:0] mem_idx;
  logic [7:0] mem_wdata;
  logic [NP-1:0] rise_ev;
  logic [NP-1:0] fall_ev;
  record_s    push_rec;
  logic       axis_hit;

  stream_if #(.WIDTH($bits(record_s))) push_s ();
  stream_if #(.WIDTH($bits(record_s))) pop_s ();

  // ==========================================================
  // Helpers
  function automatic logic [7:0] next_idx(input logic [7:0] i);
    next_idx = (i == `LAST_SLOT) ? 8'h00 : i + 8'h01;
  endfunction

  function automatic logic [9:0] slot_byte(input logic [7:0] s, input logic [3:0] k);
    slot_byte = 10'(s) * `ENTRY_BYTES + 10'(k);
  endfunction

  function automatic logic [7:0] rec_byte(input record_s r, input logic [3:0] k);
    logic [79:0] flat;
    flat     = r;
    rec_byte = flat[79 - 8*k -: 8];
  endfunction

  function automatic logic edge_hit(input logic [1:0] sel, input logic r, input logic f);
    edge_hit = (sel[0] && r) || (sel[1] && f);
  endfunction

  // ==========================================================
  // Record buffer between scanner and ring writer
  // several entries per axis may wait
  record_fifo #(.WIDTH($bits(record_s)), .DEPTH(`FIFO_DEPTH)) u_fifo (
    .clock (clock),
    .rst   (rst),
    .push  (push_s),
    .pop   (pop_s)
  );

  // Filtered edges: level moves when second and third stages agree
  assign rise_ev = (q.s2 & q.s3) & ~q.lvl;
  assign fall_ev = ~(q.s2 | q.s3) & q.lvl;

  // Record for the axis under the scan pointer
  always_comb begin
    push_rec      = '0;
    push_rec.pos  = enc_pos[32*q.scan_axis +: 32];
    push_rec.axis = 8'(q.scan_axis);
    push_rec.home = 8'(q.home_snap[3*q.scan_axis +: 3]);
    // input masks on the chosen axis
    if (q.snap_gaxis == q.scan_axis) begin
      push_rec.rise = q.rise_snap;
      push_rec.fall = q.fall_snap;
    end
    axis_hit = has_encoder[q.scan_axis] &&
               ((push_rec.home != 8'h00) || (push_rec.rise != '0) || (push_rec.fall != '0));
  end

  // Scanner pushes, writer pops only while idle
  assign push_s.data  = push_rec;
  assign push_s.valid = q.scanning && axis_hit;
  assign pop_s.ready  = (q.wst == WR_IDLE);

  // ==========================================================
  // Next state
  always_comb begin
    d         = q;
    mem_we    = 1'b0;
    mem_idx   = slot_byte(q.ins, q.byte_k);
    mem_wdata = rec_byte(q.rec, q.byte_k);

    // Three stage pin synchronisers
    d.s1  = {gpio_pin, index_pin, home_pin};
    d.s2  = q.s1;
    d.s3  = q.s2;
    // Per bit, so a bouncing pin does not hold back the others
    d.lvl = (q.s3 & ~(q.s2 ^ q.s3)) | (q.lvl & (q.s2 ^ q.s3));

    // snapshot at the update tick, scanner then walks axes
    if (update_tick && !q.scanning) begin
      d.home_snap  = q.home_pend;
      d.rise_snap  = q.rise_pend;
      d.fall_snap  = q.fall_pend;
      d.snap_gaxis = gpio_axis;
      d.home_pend  = '0;
      d.rise_pend  = '0;
      d.fall_pend  = '0;
      d.scanning   = 1'b1;
      d.scan_axis  = 2'd0;
    end else if (q.scanning && (!axis_hit || push_s.ready)) begin
      d.scanning  = (q.scan_axis != 2'(`NUM_AXES-1));
      d.scan_axis = q.scan_axis + 2'd1;
    end

    // edge selection; new events set after the clear so none are lost
    for (int a = 0; a < `NUM_AXES; a++) begin
      if (has_encoder[a]) begin
        if (edge_hit(home_sel[2*a +: 2], 1'b1, 1'b0) && rise_ev[a]) begin
          d.home_pend[3*a + `HOME_RISE_BIT] = 1'b1;
        end
        if (edge_hit(home_sel[2*a +: 2], 1'b0, 1'b1) && fall_ev[a]) begin
          d.home_pend[3*a + `HOME_FALL_BIT] = 1'b1;
        end
        if (rise_ev[`NUM_AXES + a]) begin
          d.home_pend[3*a + `ENC_HOME_BIT] = 1'b1;
        end
      end
    end
    // only inputs that fired are marked
    for (int g = 0; g < `NUM_GPIO; g++) begin
      if (edge_hit(gpio_sel[2*g +: 2], rise_ev[2*`NUM_AXES + g], 1'b0)) begin
        d.rise_pend[g] = 1'b1;
      end
      if (edge_hit(gpio_sel[2*g +: 2], 1'b0, fall_ev[2*`NUM_AXES + g])) begin
        d.fall_pend[g] = 1'b1;
      end
    end

    // Host removal index write, valid slots only
    if (host_wr && host_addr == `REM_IDX_OFS && host_wdata <= `LAST_SLOT) begin
      d.rem = host_wdata;
    end

    // Ring writer
    case (q.wst)
      WR_IDLE: begin
        if (pop_s.valid) begin
          d.rec    = pop_s.data;
          d.byte_k = 4'd0;
          d.wst    = WR_BYTES;
        end
      end
      WR_BYTES: begin
        // big-endian byte stream into the slot
        mem_we   = 1'b1;
        d.byte_k = q.byte_k + 4'd1;
        if (q.byte_k == `LAST_BYTE) begin
          d.wst = WR_ADV;
        end
      end
      WR_ADV: begin
        d.ins = next_idx(q.ins);
        if (next_idx(q.ins) == q.rem) begin
          d.rem = next_idx(q.rem);
        end
        d.wst = WR_IDLE;
      end
      default: d.wst = WR_IDLE;
    endcase

    // host read decode of the capture area and status
    d.rdata = 8'h00;
    if (host_rd) begin
      // index bytes ahead of the table
      if (host_addr == `INS_IDX_OFS) begin
        d.rdata = q.ins;
      end else if (host_addr == `REM_IDX_OFS) begin
        d.rdata = q.rem;
      end else if (host_addr >= `TABLE_OFS && host_addr <= `AREA_END_OFS) begin
        d.rdata = ring_q[10'(host_addr - `TABLE_OFS)];
      end else if (host_addr == `PEND_BYTE_OFS) begin
        // pending flag in bit 0 of this byte
        d.rdata[`PEND_BIT] = (q.ins != q.rem);
      end
    end
  end

  // Registered state
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      q     <= '0;
      q.wst <= WR_IDLE;
    end else begin
      q <= d;
    end
  end

  // Entry table storage
  always_ff @(posedge clock) begin
    if (mem_we) begin
      ring_q[mem_idx] <= mem_wdata;
    end
  end

  // Outputs from the registered state
  assign host_rdata   = q.rdata;
  // word bit 8 is byte 0xFCA bit 0 in big-endian order; empty when equal
  assign data_waiting = (q.ins != q.rem);

  // ==========================================================
  // Checks
  sequence entry_bytes_s;
    mem_we [*8] ##1 mem_we ##1 mem_we;
  endsequence

  a_index_range: assert property (@(posedge clock) disable iff (rst)
    q.ins <= `LAST_SLOT && q.rem <= `LAST_SLOT) else $error("index out of range");

  a_entry_length: assert property (@(posedge clock) disable iff (rst)
    $rose(q.wst == WR_BYTES) |-> entry_bytes_s ##1 (q.wst == WR_ADV))
    else $error("entry not ten bytes");

  a_insert_step: assert property (@(posedge clock) disable iff (rst)
    (q.wst == WR_ADV) |=> (q.ins == next_idx($past(q.ins)))) else $error("insert not advanced");

  a_overrun_drop: assert property (@(posedge clock) disable iff (rst)
    (q.wst == WR_ADV && next_idx(q.ins) == q.rem) |=> (q.rem == next_idx($past(q.rem))))
    else $error("removal not advanced on overrun");

  a_pend_byte: assert property (@(posedge clock) disable iff (rst)
    (host_rd && host_addr == `PEND_BYTE_OFS) |=> (host_rdata == {7'h00, $past(data_waiting)}))
    else $error("pending byte wrong");

  a_encoder_only: assert property (@(posedge clock) disable iff (rst)
    (mem_we && q.byte_k == 4'd4) |-> has_encoder[mem_wdata[1:0]])
    else $error("entry on axis without encoder");

  a_first_byte: assert property (@(posedge clock) disable iff (rst)
    (mem_we && q.byte_k == 4'd0) |-> (mem_wdata == q.rec.pos[31:24]))
    else $error("position MSB not first");

  a_home_code: assert property (@(posedge clock) disable iff (rst)
    (mem_we && q.byte_k == 4'd5) |-> (mem_wdata[7:3] == 5'h00)) else $error("bad home code");

  a_scan_bound: assert property (@(posedge clock) disable iff (rst)
    (update_tick && !q.scanning) |=> ##[1:40] !q.scanning) else $error("scan did not finish");
endmodule // position_capture_ring

// [inc/capture_defines.svh]
`ifndef CAPTURE_DEFINES_SVH
`define CAPTURE_DEFINES_SVH

// ==========================================================
// Shared memory map
`define INS_IDX_OFS   12'hD94
`define REM_IDX_OFS   12'hD95
`define TABLE_OFS     12'hD96
`define AREA_END_OFS  12'hFBB
`define STAT2_OFS     12'hFC8
`define PEND_BYTE_OFS 12'hFCA

// ==========================================================
// Ring geometry
`define LAST_SLOT     8'd54
`define ENTRY_BYTES   10'd10
`define LAST_BYTE     4'd9
`define TABLE_BYTES   550

// ==========================================================
// Entry field codes and pending status bit
`define HOME_RISE_BIT 0
`define ENC_HOME_BIT  1
`define HOME_FALL_BIT 2
`define PEND_BIT      0

// ==========================================================
// Sizes
`define NUM_AXES      4
`define NUM_GPIO      16
`define FIFO_DEPTH    8

`endif

// [inc/capture_pkg.sv]
package capture_pkg;
  // ==========================================================
  // Edge selection per input
  typedef enum logic [1:0] {
    SEL_OFF  = 2'b00,
    SEL_RISE = 2'b01,
    SEL_FALL = 2'b10,
    SEL_ANY  = 2'b11
  } edge_sel_e;

  // Ring writer states, one bit flips per step except WR_ADV back to WR_IDLE
  typedef enum logic [1:0] {
    WR_IDLE  = 2'b00,
    WR_BYTES = 2'b01,
    WR_ADV   = 2'b11
  } wr_state_e;

  // One captured entry in table byte order
  typedef struct packed {
    logic [31:0] pos;
    logic [7:0]  axis;
    logic [7:0]  home;
    logic [15:0] rise;
    logic [15:0] fall;
  } record_s;
endpackage

// [inc/stream_if.sv]
`timescale 1ns/1ns
interface stream_if #(parameter int WIDTH = 80);
  logic [WIDTH-1:0] data;
  logic             valid;
  logic             ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface

// [verilog/record_fifo.sv]
`timescale 1ns/1ns
module record_fifo #(
  parameter int WIDTH = 80,
  parameter int DEPTH = 8
) (
  input wire logic clock,
  input wire logic rst,
  stream_if.snk    push,
  stream_if.src    pop
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             do_push;
  logic             do_pop;

  // ==========================================================
  // Handshakes
  assign push.ready = (cnt_q != (AW+1)'(DEPTH));
  assign pop.valid  = (cnt_q != '0);
  assign pop.data   = mem_q[rd_q];
  assign do_push    = push.valid && push.ready;
  assign do_pop     = pop.valid && pop.ready;

  // Pointers and fill count
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (do_push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (do_pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end

  // Data array, no reset needed
  always_ff @(posedge clock) begin
    if (do_push) begin
      mem_q[wr_q] <= push.data;
    end
  end
endmodule // record_fifo

// [test/host_model.sv]
`timescale 1ns/1ns
`include "capture_defines.svh"
module host_model
  import capture_pkg::*;
(
  input  wire logic        clock,
  input  wire logic [7:0]  host_rdata,
  output logic      [11:0] host_addr,
  output logic             host_rd,
  output logic             host_wr,
  output logic      [7:0]  host_wdata
);
  // ==========================================================
  // Idle bus
  // Bus starts quiet
  initial begin
    host_addr  = 12'h000;
    host_rd    = 1'b0;
    host_wr    = 1'b0;
    host_wdata = 8'h00;
  end

  // ==========================================================
  // Byte access
  // Request held over one sampling edge, then the bus is scrambled
  task automatic access(input logic [11:0] a, input logic w, input logic [7:0] d,
                        output logic [7:0] q);
    @(posedge clock);
    #1;
    host_addr  = a;
    host_rd    = !w;
    host_wr    = w;
    host_wdata = d;
    @(posedge clock);
    #1;
    q          = host_rdata;
    host_rd    = 1'b0;
    host_wr    = 1'b0;
    host_addr  = ~host_addr;
    host_wdata = ~host_wdata;
  endtask

  // ==========================================================
  // Entry removal
  // slot read, byte assembly, index wrap
  task automatic take_entry(output record_s rec);
    logic [7:0]  r;
    logic [7:0]  b;
    logic [79:0] raw;
    raw = 80'h0;
    access(`REM_IDX_OFS, 1'b0, 8'h00, r);
    for (int i = 0; i < 10; i++) begin
      access(`TABLE_OFS + 12'(r) * 12'd10 + 12'(i), 1'b0, 8'h00, b);
      raw = {raw[71:0], b};
    end
    rec = raw;
    access(`REM_IDX_OFS, 1'b1, (r == 8'd54) ? 8'h00 : r + 8'h01, b);
  endtask
endmodule // host_model

// [test/tb_top.sv]
`timescale 1ns/1ns
`include "capture_defines.svh"
module tb_top
  import capture_pkg::*;
;
  // ==========================================================
  // Signals
  logic                    clock, rst, update_tick, data_waiting;
  logic [`NUM_AXES-1:0]    home_pin, index_pin, has_encoder;
  logic [`NUM_GPIO-1:0]    gpio_pin;
  logic [`NUM_AXES*32-1:0] enc_pos;
  logic [`NUM_AXES*2-1:0]  home_sel;
  logic [`NUM_GPIO*2-1:0]  gpio_sel;
  logic [1:0]              gpio_axis;
  logic [11:0]             host_addr;
  logic                    host_rd, host_wr;
  logic [7:0]              host_wdata, host_rdata, rb, ins_exp;
  int                      fails, comparisons;
  record_s                 exp_q[$];
  record_s                 got;
  logic [11:0]             quiet_a [5] = '{12'hFC8, 12'hFC9, 12'hFCB, 12'hFBC, 12'h100};

  // ==========================================================
  // Instances
  position_capture_ring position_capture_ring_inst (
    .clock(clock), .rst(rst), .update_tick(update_tick), .home_pin(home_pin),
    .index_pin(index_pin), .gpio_pin(gpio_pin), .enc_pos(enc_pos),
    .has_encoder(has_encoder), .home_sel(home_sel), .gpio_sel(gpio_sel),
    .gpio_axis(gpio_axis), .host_addr(host_addr), .host_rd(host_rd), .host_wr(host_wr),
    .host_wdata(host_wdata), .host_rdata(host_rdata), .data_waiting(data_waiting));
  host_model host_model_inst (
    .clock(clock), .host_rdata(host_rdata), .host_addr(host_addr), .host_rd(host_rd),
    .host_wr(host_wr), .host_wdata(host_wdata));

  // ==========================================================
  // Checking and closing
  // Compare one value and count it
  task automatic check(input string what, input logic [79:0] seen, input logic [79:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Verdict and stop
  task automatic end_sim();
    if (fails == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Expectations
  // Entries of one tick from pin levels before and after
  function automatic void predict(input logic [3:0] h0, h1, x0, x1,
                                  input logic [15:0] g0, g1);
    record_s r;
    for (int a = 0; a < `NUM_AXES; a++) begin
      r = '0;
      r.pos  = enc_pos[32*a +: 32];
      r.axis = 8'(a);
      r.home = {5'h00, h0[a] & !h1[a] & home_sel[2*a+1], !x0[a] & x1[a],
                !h0[a] & h1[a] & home_sel[2*a]};
      for (int i = 0; i < `NUM_GPIO; i++) begin
        r.rise[i] = (gpio_axis == a) && !g0[i] && g1[i] && gpio_sel[2*i];
        r.fall[i] = (gpio_axis == a) && g0[i] && !g1[i] && gpio_sel[2*i+1];
      end
      if (has_encoder[a] && {r.home, r.rise, r.fall} != 40'h0) begin
        exp_q.push_back(r);
        ins_exp = (ins_exp == 8'd54) ? 8'h00 : ins_exp + 8'h01;
      end
    end
    while (exp_q.size() > 54) begin
      void'(exp_q.pop_front());
    end
  endfunction

  // ==========================================================
  // Stimulus tasks
  // New pin levels, then one update tick and time for the writer
  task automatic event_tick(input logic [3:0] h, x, input logic [15:0] g);
    predict(home_pin, h, index_pin, x, gpio_pin, g);
    home_pin  = h;
    index_pin = x;
    gpio_pin  = g;
    repeat (8) @(posedge clock);
    #1 update_tick = 1'b1;
    @(posedge clock);
    #1 update_tick = 1'b0;
    repeat (80) @(posedge clock);
    #1;
  endtask

  // Pending flag on the pin and in the status byte
  task automatic status();
    host_model_inst.access(`PEND_BYTE_OFS, 1'b0, 8'h00, rb);
    check("pending byte", rb, {7'h00, exp_q.size() != 0});
    check("waiting", data_waiting, exp_q.size() != 0);
  endtask

  // Host takes every entry and compares it
  task automatic drain();
    status();
    while (exp_q.size() > 0) begin
      host_model_inst.take_entry(got);
      check("entry", got, exp_q.pop_front());
    end
    status();
  endtask

  // ==========================================================
  // Clock and watchdog
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Cuts a hang short
  initial begin
    repeat (60000) @(posedge clock);
    fails++;
    end_sim();
  end

  // ==========================================================
  // Main sequence
  initial begin
    rst = 1'b1;
    update_tick = 1'b0;
    home_pin = 4'h0;
    index_pin = 4'h0;
    gpio_pin = 16'h0000;
    enc_pos = '0;
    home_sel = 8'hFF;
    gpio_sel = 32'hFFFFFFFF;
    gpio_axis = 2'h0;
    ins_exp = 8'h00;
    fails = 0;
    comparisons = 0;
    void'($urandom(75920));
    has_encoder = (4'($urandom) | 4'h1) & 4'h7;
    repeat (8) @(posedge clock);
    #1 rst = 1'b0;
    // Read-only and out of range writes are ignored
    host_model_inst.access(`INS_IDX_OFS, 1'b1, 8'h07, rb);
    host_model_inst.access(`REM_IDX_OFS, 1'b1, 8'h37, rb);
    host_model_inst.access(`INS_IDX_OFS, 1'b0, 8'h00, rb);
    check("insert index", rb, 8'h00);
    host_model_inst.access(`REM_IDX_OFS, 1'b0, 8'h00, rb);
    check("removal index", rb, 8'h00);
    foreach (quiet_a[k]) begin
      host_model_inst.access(quiet_a[k], 1'b0, 8'h00, rb);
      check("quiet byte", rb, 8'h00);
    end
    status();
    // Every input rising, then every input falling
    enc_pos = {$urandom, $urandom, $urandom, $urandom};
    event_tick(4'hF, 4'hF, 16'hFFFF);
    drain();
    event_tick(4'h0, 4'h0, 16'h0000);
    drain();
    // Random selections, entries left to pile up across ticks
    for (int n = 0; n < 30; n++) begin
      home_sel = 8'($urandom);
      gpio_sel = $urandom;
      enc_pos = {$urandom, $urandom, $urandom, $urandom};
      do gpio_axis = 2'($urandom); while (!has_encoder[gpio_axis]);
      event_tick(4'($urandom), 4'($urandom), 16'($urandom));
      if (n % 3 == 2) begin
        drain();
      end
    end
    drain();
    // Host falls behind until the ring overruns
    home_sel = 8'hFF;
    for (int n = 0; n < 57; n++) begin
      enc_pos = {$urandom, $urandom, $urandom, $urandom};
      event_tick(home_pin ^ 4'h1, index_pin, gpio_pin);
    end
    host_model_inst.access(`INS_IDX_OFS, 1'b0, 8'h00, rb);
    check("insert index", rb, ins_exp);
    host_model_inst.access(`REM_IDX_OFS, 1'b0, 8'h00, rb);
    check("removal index", rb, (ins_exp == 8'd54) ? 8'h00 : ins_exp + 8'h01);
    drain();
    end_sim();
  end
endmodule // tb_top
